// File: src/dpm_pkg.sv
package dpm_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_MAP_2A_2B = 14'h0355;
    localparam logic [13:0] IDX_MAP_2C_2D = 14'h0350;
    localparam logic [13:0] IDX_MAP_2E_2F = 14'h0357;
    localparam logic [13:0] IDX_MAP_30_31 = 14'h0358;
    localparam logic [13:0] IDX_MAP_32_33 = 14'h0359;
    localparam logic [13:0] IDX_MAP_34_35 = 14'h035A;
    localparam logic [13:0] IDX_MAP_36_37 = 14'h035B;
    localparam logic [13:0] IDX_MAP_38_39 = 14'h035C;
    localparam logic [13:0] IDX_MAP_3A_3B = 14'h035D;
    localparam logic [13:0] IDX_MAP_3C_3D = 14'h035E;

    // ------------------------------------------------------------
    // Bank geometry and field layout
    // ------------------------------------------------------------
    localparam int NUM_REGS = 10;
    localparam int FIELD_W = 3;
    localparam int FLD_LO_LSB = 0;
    localparam int FLD_HI_LSB = 4;
    localparam int ADDR_W = 16;
    localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h0;
    localparam logic [5:0] CP_FIRST = 6'h2A;
    localparam logic [5:0] CP_LAST = 6'h3D;

    // Slot k holds the code points CP_FIRST + 2k (low field) and CP_FIRST + 2k + 1 (high field).
    localparam logic [NUM_REGS-1:0][13:0] SLOT_IDX = {
        IDX_MAP_3C_3D, IDX_MAP_3A_3B, IDX_MAP_38_39, IDX_MAP_36_37, IDX_MAP_34_35,
        IDX_MAP_32_33, IDX_MAP_30_31, IDX_MAP_2E_2F, IDX_MAP_2C_2D, IDX_MAP_2A_2B
    };

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [NUM_REGS-1:0][2*FIELD_W-1:0] dpm_fields_t;

endpackage

// File: src/dpm_map_if.sv
`timescale 1ns/10ps
interface dpm_map_if;
    // Stored fields, slot k as {high field, low field}.
    dpm_pkg::dpm_fields_t fields;
    // Code point presented by the classifier.
    logic [5:0] code_point;
    // Looked-up priority and whether the code point falls in this bank.
    logic [2:0] prio;
    logic hit;

    modport bank
    (
        output fields,
        output code_point,
        input prio,
        input hit
    );

    modport lookup
    (
        input fields,
        input code_point,
        output prio,
        output hit
    );
endinterface

// File: src/dpm_slot_decode.sv
`timescale 1ns/10ps
module dpm_slot_decode
(
    // Word index from the bus.
    input wire logic [13:0] idx,
    // Decoded slot.
    output logic hit,
    output logic [3:0] slot
);
    logic [dpm_pkg::NUM_REGS-1:0] match;

    // One comparator per mapping register.
    genvar g;
    generate
        for (g = 0; g < dpm_pkg::NUM_REGS; g++)
        begin : g_match
            assign match[g] = (idx == dpm_pkg::SLOT_IDX[g]);
        end
    endgenerate

    // Encode the single matching comparator into a slot number.
    always_comb
    begin
        hit = |match;
        slot = 4'h0;
        for (int i = 0; i < dpm_pkg::NUM_REGS; i++)
        begin
            if (match[i])
            begin
                slot = 4'(i);
            end
        end
    end
endmodule

// File: src/dpm_prio_lookup.sv
`timescale 1ns/10ps
module dpm_prio_lookup
(
    // Bank side of the lookup.
    dpm_map_if.lookup map
);
    logic [5:0] offset;
    logic [3:0] slot;

    // Pure combinational select from the stored fields, so a new field value is seen at once.
    always_comb
    begin
        offset = map.code_point - dpm_pkg::CP_FIRST;
        slot = offset[4:1];
        map.hit = (map.code_point >= dpm_pkg::CP_FIRST) && (map.code_point <= dpm_pkg::CP_LAST);
        map.prio = 3'h0;
        if (map.hit)
        begin
            // Odd code points take the high field, even ones the low field.
            if (offset[0])
            begin
                map.prio = map.fields[slot][2*dpm_pkg::FIELD_W-1:dpm_pkg::FIELD_W];
            end
            else
            begin
                map.prio = map.fields[slot][dpm_pkg::FIELD_W-1:0];
            end
        end
    end
endmodule

// File: src/dpm_map_top.sv
// How it works
// - Code point 2A/2B use register 0x355.
// - Code point 2C/2D use register 0x350.
// - Code point 2E/2F use register 0x357.
// - Code point 30/31 use register 0x358.
// - Code point 32/33 use register 0x359.
// - Code point 34/35 use register 0x35A.
// - Code point 36/37 use register 0x35B.
// - Code point 38/39 use register 0x35C.
// - Code point 3A/3B use register 0x35D.
// - Code point 3C/3D use register 0x35E.
`timescale 1ns/10ps
module dpm_map_top
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Write address channel.
    input wire logic [dpm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel.
    input wire logic [dpm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Classifier lookup.
    input wire logic [5:0] cp_in,
    output logic [2:0] prio_out,
    output logic prio_hit
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dpm_pkg::dpm_fields_t fields;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic aw_have;
        logic w_have;
        logic [dpm_pkg::ADDR_W-1:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] prio;
        logic hit;
    } dpm_state_s;

    dpm_state_s st;
    dpm_state_s next_st;
    logic wr_hit;
    logic [3:0] wr_slot;
    logic rd_hit;
    logic [3:0] rd_slot;
    logic do_write;

    dpm_map_if map ();

    // ------------------------------------------------------------
    // Address decode and lookup
    // ------------------------------------------------------------
    dpm_slot_decode u_wr_decode
    (
        .idx(st.aw_addr[15:2]),
        .hit(wr_hit),
        .slot(wr_slot)
    );

    dpm_slot_decode u_rd_decode
    (
        .idx(s_axi_araddr[15:2]),
        .hit(rd_hit),
        .slot(rd_slot)
    );

    // The classifier sees the fields exactly as stored now.
    assign map.fields = st.fields;
    assign map.code_point = cp_in;

    dpm_prio_lookup u_lookup
    (
        .map(map.lookup)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus handshakes, register writes, read data and the registered lookup result.
    always_comb
    begin
        next_st = st;
        do_write = 1'b0;

        // A finished write response reopens both write channels.
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.aw_rdy = 1'b1;
            next_st.w_rdy = 1'b1;
        end

        // Address and data are taken independently, in either order.
        if (s_axi_awvalid && st.aw_rdy)
        begin
            next_st.aw_addr = s_axi_awaddr;
            next_st.aw_have = 1'b1;
            next_st.aw_rdy = 1'b0;
        end
        if (s_axi_wvalid && st.w_rdy)
        begin
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
            next_st.w_have = 1'b1;
            next_st.w_rdy = 1'b0;
        end

        // Both halves held: update the bank and answer.
        if (st.aw_have && st.w_have && !st.bvalid)
        begin
            do_write = wr_hit && st.w_lane0;
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_hit ? dpm_pkg::RESP_OKAY : dpm_pkg::RESP_SLVERR;
            if (do_write)
            begin
                // Reserved bits 7 and 3 are dropped here.
                next_st.fields[wr_slot] = {st.w_data[dpm_pkg::FLD_HI_LSB +: dpm_pkg::FIELD_W],
                    st.w_data[dpm_pkg::FLD_LO_LSB +: dpm_pkg::FIELD_W]};
            end
        end

        // A finished read reopens the read address channel.
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.ar_rdy = 1'b1;
        end

        // Read: reserved and upper bits return zero, unmapped words answer SLVERR.
        if (s_axi_arvalid && st.ar_rdy)
        begin
            next_st.ar_rdy = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = dpm_pkg::RESP_SLVERR;
            if (rd_hit)
            begin
                next_st.rresp = dpm_pkg::RESP_OKAY;
                next_st.rdata[dpm_pkg::FLD_HI_LSB +: dpm_pkg::FIELD_W] =
                    st.fields[rd_slot][2*dpm_pkg::FIELD_W-1:dpm_pkg::FIELD_W];
                next_st.rdata[dpm_pkg::FLD_LO_LSB +: dpm_pkg::FIELD_W] =
                    st.fields[rd_slot][dpm_pkg::FIELD_W-1:0];
            end
        end

        // Priority for the current code point, held one cycle for a clean output.
        next_st.prio = map.prio;
        next_st.hit = map.hit;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // All fields clear at reset; the three address/data channels open ready.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.aw_rdy <= 1'b1;
            st.w_rdy <= 1'b1;
            st.ar_rdy <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a state bit.
    assign s_axi_awready = st.aw_rdy;
    assign s_axi_wready = st.w_rdy;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.ar_rdy;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign prio_out = st.prio;
    assign prio_hit = st.hit;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // Each code point pair returns the right field of its register one cycle later.
    a_map_2a_2b: assert property ((cp_in == 6'h2A) |=> (prio_out == $past(st.fields[0][2:0])))
        else $error("Code point 2A gave wrong priority.");
    a_map_2c_2d: assert property ((cp_in == 6'h2D) |=> (prio_out == $past(st.fields[1][5:3])))
        else $error("Code point 2D gave wrong priority.");
    a_map_2e_2f: assert property ((cp_in == 6'h2E) |=> (prio_out == $past(st.fields[2][2:0])))
        else $error("Code point 2E gave wrong priority.");
    a_map_30_31: assert property ((cp_in == 6'h31) |=> (prio_out == $past(st.fields[3][5:3])))
        else $error("Code point 31 gave wrong priority.");
    a_map_32_33: assert property ((cp_in == 6'h32) |=> (prio_out == $past(st.fields[4][2:0])))
        else $error("Code point 32 gave wrong priority.");
    a_map_34_35: assert property ((cp_in == 6'h35) |=> (prio_out == $past(st.fields[5][5:3])))
        else $error("Code point 35 gave wrong priority.");
    a_map_36_37: assert property ((cp_in == 6'h36) |=> (prio_out == $past(st.fields[6][2:0])))
        else $error("Code point 36 gave wrong priority.");
    a_map_38_39: assert property ((cp_in == 6'h39) |=> (prio_out == $past(st.fields[7][5:3])))
        else $error("Code point 39 gave wrong priority.");
    a_map_3a_3b: assert property ((cp_in == 6'h3A) |=> (prio_out == $past(st.fields[8][2:0])))
        else $error("Code point 3A gave wrong priority.");
    a_map_3c_3d: assert property ((cp_in == 6'h3D) |=> (prio_out == $past(st.fields[9][5:3])))
        else $error("Code point 3D gave wrong priority.");

    // The other code point of each pair takes the other field of the same register.
    a_map_2b: assert property ((cp_in == 6'h2B) |=> (prio_out == $past(st.fields[0][5:3])))
        else $error("Code point 2B gave wrong priority.");
    a_map_2c: assert property ((cp_in == 6'h2C) |=> (prio_out == $past(st.fields[1][2:0])))
        else $error("Code point 2C gave wrong priority.");
    a_map_2f: assert property ((cp_in == 6'h2F) |=> (prio_out == $past(st.fields[2][5:3])))
        else $error("Code point 2F gave wrong priority.");
    a_map_30: assert property ((cp_in == 6'h30) |=> (prio_out == $past(st.fields[3][2:0])))
        else $error("Code point 30 gave wrong priority.");
    a_map_33: assert property ((cp_in == 6'h33) |=> (prio_out == $past(st.fields[4][5:3])))
        else $error("Code point 33 gave wrong priority.");
    a_map_34: assert property ((cp_in == 6'h34) |=> (prio_out == $past(st.fields[5][2:0])))
        else $error("Code point 34 gave wrong priority.");
    a_map_37: assert property ((cp_in == 6'h37) |=> (prio_out == $past(st.fields[6][5:3])))
        else $error("Code point 37 gave wrong priority.");
    a_map_38: assert property ((cp_in == 6'h38) |=> (prio_out == $past(st.fields[7][2:0])))
        else $error("Code point 38 gave wrong priority.");
    a_map_3b: assert property ((cp_in == 6'h3B) |=> (prio_out == $past(st.fields[8][5:3])))
        else $error("Code point 3B gave wrong priority.");
    a_map_3c: assert property ((cp_in == 6'h3C) |=> (prio_out == $past(st.fields[9][2:0])))
        else $error("Code point 3C gave wrong priority.");

    // Read data never shows reserved or upper bits.
    a_rsvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata[31:7] == 25'h0) && !s_axi_rdata[3])
        else $error("Reserved read bit is set.");

    // A write lands in the bank one edge later and answers OKAY.
    a_write_lands: assert property (do_write |=> (st.fields[$past(wr_slot)] ==
        {$past(st.w_data[6:4]), $past(st.w_data[2:0])}) && s_axi_bvalid && (s_axi_bresp == 2'h0))
        else $error("Register write did not take effect.");

    // An unmapped write answers SLVERR and leaves the bank alone.
    a_unmapped_err: assert property ((st.aw_have && st.w_have && !st.bvalid && !wr_hit) |=>
        (s_axi_bresp == dpm_pkg::RESP_SLVERR) && $stable(st.fields))
        else $error("Unmapped write was not refused.");

    // A write with byte lane 0 off answers but stores nothing.
    a_lane_off: assert property ((st.aw_have && st.w_have && !st.bvalid && !st.w_lane0) |=>
        $stable(st.fields))
        else $error("Write with lane 0 off changed the bank.");

    // An unmapped read answers SLVERR with zero data.
    a_read_err: assert property ((s_axi_arvalid && s_axi_arready && !rd_hit) |=> s_axi_rvalid &&
        (s_axi_rresp == dpm_pkg::RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000))
        else $error("Unmapped read was not refused.");

    // A mapped read returns both fields in their bit positions and zero elsewhere.
    a_read_data: assert property ((s_axi_arvalid && s_axi_arready && rd_hit) |=> s_axi_rvalid &&
        (s_axi_rresp == dpm_pkg::RESP_OKAY) &&
        (s_axi_rdata == {25'h0, $past(st.fields[rd_slot][5:3]), 1'b0, $past(st.fields[rd_slot][2:0])}))
        else $error("Register read returned wrong data.");

    // While a write response waits, neither write channel takes a new transfer.
    a_wr_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write channel open during response.");

    // While read data waits, the read address channel stays closed.
    a_rd_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address channel open during response.");

    // The hit flag follows whether the previous code point lay in this bank.
    a_hit_range: assert property ($past(arst_n) |->
        (prio_hit == $past((cp_in >= dpm_pkg::CP_FIRST) && (cp_in <= dpm_pkg::CP_LAST))))
        else $error("Hit flag wrong for code point.");

    // Code points outside this bank give priority zero.
    a_miss_zero: assert property (!prio_hit |-> (prio_out == 3'h0))
        else $error("Priority not zero outside the bank.");
endmodule

// File: sim/dpm_map_top_tb.sv
`timescale 1ns/10ps
module dpm_map_top_tb;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic core_clk;
    logic arst_n;
    logic [15:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [15:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic [5:0] cp_in;
    logic [2:0] prio_out;
    logic prio_hit;
    int n_mismatch;
    int checked;
    int cycles;
    int k;
    logic [2:0] lo;
    logic [2:0] hi;
    // Word indices of the ten mapping registers, slot k serves code points 2A+2k and 2B+2k.
    logic [13:0] idx_tab [10] = '{14'h0355, 14'h0350, 14'h0357, 14'h0358, 14'h0359,
                                  14'h035A, 14'h035B, 14'h035C, 14'h035D, 14'h035E};

    dpm_map_top dut
    (
        .core_clk(core_clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cp_in(cp_in), .prio_out(prio_out), .prio_hit(prio_hit)
    );

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    // The clock toggles every 10 ns, half its period of 20 ns.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // A hung handshake is cut short after a fixed number of cycles.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Compares a bus word or response.
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares the lookup result as {hit, priority}.
    task automatic cmp_prio(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Writes one word; each channel is released at the edge that takes it.
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge core_clk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
        // Bready stays high, so back-to-back writes never drive it twice in one step.
        cmp_word({30'h0, bresp}, {30'h0, er});
    endtask

    // Reads one word and checks data and response.
    task automatic axi_read(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge core_clk);
        // Rready stays high, so back-to-back reads never drive it twice in one step.
        cmp_word(rdata, ed);
        cmp_word({30'h0, rresp}, {30'h0, er});
    endtask

    // Presents a code point and checks the registered lookup two clock edges later.
    task automatic look(input logic [5:0] cp, input logic hit, input logic [2:0] p);
        cp_in <= cp;
        @(posedge core_clk);
        @(posedge core_clk);
        cmp_prio({prio_hit, prio_out}, {hit, p});
    endtask

    // Byte address of slot k.
    function automatic logic [15:0] addr_of(input int n);
        return {idx_tab[n], 2'b00};
    endfunction

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    // Resets the block, then runs the tests one after another.
    initial
    begin
        arst_n = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, cp_in} = '0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        for (k = 0; k < 10; k++)
        begin
            axi_read(addr_of(k), 32'h0, dpm_pkg::RESP_OKAY);
            look(6'(6'h2A + 2 * k), 1'b1, 3'h0);
        end
        $display("test reset_values done");
        for (k = 0; k < 10; k++)
        begin
            lo = 3'(k + 1);
            hi = 3'(k + 3);
            axi_write(addr_of(k), {24'hA5A5A5, 1'b1, hi, 1'b1, lo}, 4'hF, dpm_pkg::RESP_OKAY);
            look(6'(6'h2A + 2 * k), 1'b1, lo);
            look(6'(6'h2B + 2 * k), 1'b1, hi);
        end
        for (k = 0; k < 10; k++)
            axi_read(addr_of(k), {25'h0, 3'(k + 3), 1'b0, 3'(k + 1)}, dpm_pkg::RESP_OKAY);
        $display("test map_fields done");
        look(6'h29, 1'b0, 3'h0);
        look(6'h3E, 1'b0, 3'h0);
        look(6'h3F, 1'b0, 3'h0);
        look(6'h00, 1'b0, 3'h0);
        $display("test out_of_range done");
        axi_write(16'h0D58, 32'h0000_0077, 4'hF, dpm_pkg::RESP_SLVERR);
        axi_read(16'h0D58, 32'h0, dpm_pkg::RESP_SLVERR);
        axi_write(16'h0D50, 32'h0000_0077, 4'hF, dpm_pkg::RESP_SLVERR);
        axi_read(addr_of(1), 32'h0000_0042, dpm_pkg::RESP_OKAY);
        axi_read(addr_of(0), 32'h0000_0031, dpm_pkg::RESP_OKAY);
        axi_write(addr_of(0), 32'h0000_0077, 4'h0, dpm_pkg::RESP_OKAY);
        axi_read(addr_of(0), 32'h0000_0031, dpm_pkg::RESP_OKAY);
        $display("test refused_writes done");
        axi_write(addr_of(9), 32'h0000_0056, 4'h1, dpm_pkg::RESP_OKAY);
        look(6'h3D, 1'b1, 3'h5);
        look(6'h3C, 1'b1, 3'h6);
        axi_write(addr_of(9), 32'h0000_0000, 4'h1, dpm_pkg::RESP_OKAY);
        look(6'h3C, 1'b1, 3'h0);
        $display("test write_then_lookup done");
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        axi_read(addr_of(3), 32'h0, dpm_pkg::RESP_OKAY);
        look(6'h31, 1'b1, 3'h0);
        $display("test second_reset done");
        wrap_up();
    end

endmodule
